// ### pld_pkg.sv
package pld_pkg;
   // Register map (byte addresses on the serial register port)
   localparam logic [7:0] PORT_REG_FIRST = 8'h01;
   localparam logic [7:0] PORT_REG_LAST = 8'h09;
   localparam logic [7:0] DEV_CFG_ADDR = 8'h26;
   localparam logic [7:0] PIN_CFG_ADDR = 8'h27;
   localparam logic [7:0] LOCK_LOW_ADDR = 8'h72;
   localparam logic [7:0] LOCK_HIGH_ADDR = 8'h73;
   localparam int NPORT = 9;
   // Port register fields in input mode
   localparam int PB_DIR = 7;
   localparam int PB_SUPPLY = 6;
   localparam int PB_ALERT_EN = 5;
   localparam int PB_DEBOUNCE = 2;
   localparam int PB_TRANS = 1;
   localparam int PB_LEVEL = 0;
   // Device config fields
   localparam int DC_RESTORE = 0;
   localparam int DC_TIMER_CLR = 1;
   localparam int DC_ALERT = 7;
   localparam int DC_NOFLAG = 6;
   // Pin config fields
   localparam int PC_ALERT_SEL = 1;
   localparam int PC_EXTCLK_SEL = 2;
   // Reset values and lock write masks
   localparam logic [7:0] PORT_RESET = 8'h80;
   localparam logic [7:0] DEV_CFG_RESET = 8'h00;
   localparam logic [7:0] PIN_CFG_RESET = 8'h0E;
   localparam logic [7:0] LOCK_LOW_MASK = 8'hFA;
   localparam logic [7:0] LOCK_HIGH_MASK = 8'h0F;
   // Debounce timing, internal timebase at 32 kHz
   localparam int TIMEBASE_HZ = 32000;
   localparam int DEBOUNCE_MS = 31;
   localparam int DEBOUNCE_TICKS = (TIMEBASE_HZ * DEBOUNCE_MS) / 1000;
   localparam int TIMER_W = 16;
   // Bus command carried from the serial interface logic
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pld_cmd_t;
endpackage

// ### pld_top.sv
`timescale 1ns/1ps
module pld_top
   import pld_pkg::*;
(
   // Core clock and power-on reset
   input wire logic core_clk,
   input wire logic resetn,
   // Internal timebase clock domain
   input wire logic timebase_clk,
   // Hardware reset pin, active low, asynchronous to core
   input wire logic rst_pin_n,
   // Register port from serial interface
   input wire pld_cmd_t bus_cmd,
   input wire logic bus_stop,
   output logic [7:0] bus_rdata,
   output logic bus_abort,
   // Port pins and logic array gate monitor enables
   input wire logic [NPORT-1:0] port_in,
   input wire logic [NPORT-1:0] logic_array_gate,
   // Alert pin on the alert capable port, open drain
   output logic alert_n_o,
   output logic alert_n_oe,
   // Timing control
   output logic timing_clear,
   output logic ext_clock_select
);

   // Register state
   logic [7:0] port_q [NPORT];
   logic [7:0] port_d [NPORT];
   logic [7:0] dev_cfg_q, pin_cfg_q;
   logic [7:0] lock_low_q, lock_high_q;
   logic [7:0] bus_rdata_q;
   logic [NPORT-1:0] snap_q, deb_q, prev_q, flag_q;
   logic [NPORT-1:0] sync1_q, sync2_q;
   logic rst1_q, rst2_q;
   logic alert_q, pend_q, in_read_q;
   logic abort_q, timing_clear_q;

   // Address decode helpers
   function automatic logic is_port(input logic [7:0] a);
      return a >= PORT_REG_FIRST && a <= PORT_REG_LAST;
   endfunction
   function automatic logic [3:0] port_idx(input logic [7:0] a);
      return 4'(a - PORT_REG_FIRST);
   endfunction

   // Port pin synchroniser into core domain
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= port_in;
         sync2_q <= sync1_q;
      end
   end

   // Reset pin synchroniser
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst1_q <= 1'b1;
         rst2_q <= 1'b1;
      end else begin
         rst1_q <= rst_pin_n;
         rst2_q <= rst1_q;
      end
   end

   // Debounce tick generated in the timebase domain, sent as a toggle
   logic [TIMER_W-1:0] tb_cnt_q;
   logic tb_tog_q;
   logic tb_rst1_q, tb_rst2_q;
   always_ff @(posedge timebase_clk or negedge resetn) begin
      if (!resetn) begin
         tb_rst1_q <= 1'b0;
         tb_rst2_q <= 1'b0;
      end else begin
         tb_rst1_q <= 1'b1;
         tb_rst2_q <= tb_rst1_q;
      end
   end
   always_ff @(posedge timebase_clk or negedge resetn) begin
      if (!resetn) begin
         tb_cnt_q <= '0;
         tb_tog_q <= 1'b0;
      end else if (tb_rst2_q) begin
         if (tb_cnt_q == TIMER_W'(DEBOUNCE_TICKS - 1)) begin
            tb_cnt_q <= '0;
            tb_tog_q <= ~tb_tog_q;
         end else begin
            tb_cnt_q <= tb_cnt_q + 1'b1;
         end
      end
   end

   // Toggle crossing into core domain
   logic tog1_q, tog2_q, tog3_q;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tog1_q <= 1'b0;
         tog2_q <= 1'b0;
         tog3_q <= 1'b0;
      end else begin
         tog1_q <= tb_tog_q;
         tog2_q <= tog1_q;
         tog3_q <= tog2_q;
      end
   end
   wire sample_tick = tog2_q ^ tog3_q;

   // Bus decode
   wire logic rd_port = bus_cmd.rd && is_port(bus_cmd.addr);
   wire logic wr_port = bus_cmd.wr && is_port(bus_cmd.addr);
   wire logic [3:0] sel = port_idx(bus_cmd.addr);
   wire logic pin_reset = ~rst2_q;
   wire logic restore = pin_reset && dev_cfg_q[DC_RESTORE];
   wire logic [NPORT-1:0] lock_vec = {lock_high_q[3:0], lock_low_q[7:3]};
   wire logic lock_cfg = lock_low_q[1];

   // Per-port effective level and detection
   logic [NPORT-1:0] is_in, deb_en, level, change, rd_hit;
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         is_in[i] = port_q[i][PB_DIR] | logic_array_gate[i];
         deb_en[i] = port_q[i][PB_DEBOUNCE] & port_q[i][PB_DIR];
         level[i] = deb_en[i] ? deb_q[i] : sync2_q[i];
         change[i] = is_in[i] && (level[i] != snap_q[i]);
         rd_hit[i] = rd_port && (sel == i);
      end
   end

   // Debounce storage, updates when two samples agree
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prev_q <= '0;
         deb_q <= '0;
      end else if (sample_tick) begin
         prev_q <= sync2_q;
         deb_q <= (sync2_q ~^ prev_q) & sync2_q | (sync2_q ^ prev_q) & deb_q;
      end
   end

   // Snapshot and transition flags; read clear wins over set
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         snap_q <= '0;
         flag_q <= '0;
      end else begin
         for (int i = 0; i < NPORT; i++) begin
            if (rd_hit[i]) begin
               snap_q[i] <= level[i];
               flag_q[i] <= 1'b0;
            end else if (change[i]) begin
               flag_q[i] <= 1'b1;
            end
         end
      end
   end

   // Port register next values
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         port_d[i] = port_q[i];
         if (restore) begin
            port_d[i] = PORT_RESET;
         end else if (wr_port && sel == i && !lock_vec[i]) begin
            port_d[i] = bus_cmd.wdata;
         end
      end
   end

   // Port registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NPORT; i++) begin
            port_q[i] <= PORT_RESET;
         end
      end else begin
         for (int i = 0; i < NPORT; i++) begin
            port_q[i] <= port_d[i];
         end
      end
   end

   // Configuration and lock registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dev_cfg_q <= DEV_CFG_RESET;
         pin_cfg_q <= PIN_CFG_RESET;
         lock_low_q <= '0;
         lock_high_q <= '0;
      end else if (restore) begin
         pin_cfg_q <= PIN_CFG_RESET;
         lock_low_q <= '0;
         lock_high_q <= '0;
      end else if (bus_cmd.wr) begin
         if (bus_cmd.addr == DEV_CFG_ADDR) begin
            dev_cfg_q <= bus_cmd.wdata;
         end
         if (bus_cmd.addr == PIN_CFG_ADDR && !lock_cfg) begin
            pin_cfg_q <= bus_cmd.wdata;
         end
         if (bus_cmd.addr == LOCK_LOW_ADDR) begin
            lock_low_q <= (lock_low_q | bus_cmd.wdata) & LOCK_LOW_MASK;
         end
         if (bus_cmd.addr == LOCK_HIGH_ADDR) begin
            lock_high_q <= (lock_high_q | bus_cmd.wdata) & LOCK_HIGH_MASK;
         end
      end
   end

   // Per-port alert enables, read straight from the port registers
   logic [NPORT-1:0] alert_en;
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         alert_en[i] = port_q[i][PB_ALERT_EN];
      end
   end

   // Alert sources: enabled flags, and fresh changes not being read
   wire logic [NPORT-1:0] alert_src = flag_q & alert_en;
   wire logic new_evt = |(change & ~rd_hit & alert_en);
   wire logic any_rd = rd_port || (bus_cmd.rd && bus_cmd.addr == DEV_CFG_ADDR);

   // Read sequence tracking; a STOP or the reset pin closes it
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         in_read_q <= 1'b0;
      end else if (bus_cmd.rd) begin
         in_read_q <= 1'b1;
      end else if (bus_stop || pin_reset) begin
         in_read_q <= 1'b0;
      end
   end

   // Alert request deferred while a read sequence is open
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pend_q <= 1'b0;
      end else if (new_evt && (in_read_q || bus_cmd.rd)) begin
         pend_q <= 1'b1;
      end else if (bus_stop) begin
         pend_q <= 1'b0;
      end
   end

   // Alert latch; only a port or device config read releases it, never the pin reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         alert_q <= 1'b0;
      end else if (new_evt && !(in_read_q || bus_cmd.rd)) begin
         alert_q <= 1'b1;
      end else if (bus_stop && pend_q && |alert_src) begin
         alert_q <= 1'b1;
      end else if (any_rd) begin
         alert_q <= 1'b0;
      end
   end

   // Read data mux
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (rd_port) begin
         rd_mux = port_q[sel];
         if (port_q[sel][PB_DIR]) begin
            rd_mux[PB_TRANS] = flag_q[sel] | change[sel];
            rd_mux[PB_LEVEL] = level[sel];
            rd_mux[4:3] = 2'b00;
         end
      end else if (bus_cmd.addr == DEV_CFG_ADDR) begin
         rd_mux = dev_cfg_q;
         rd_mux[DC_ALERT] = alert_q;
         rd_mux[DC_NOFLAG] = ~|flag_q;
      end else if (bus_cmd.addr == PIN_CFG_ADDR) begin
         rd_mux = pin_cfg_q;
      end else if (bus_cmd.addr == LOCK_LOW_ADDR) begin
         rd_mux = lock_low_q;
      end else if (bus_cmd.addr == LOCK_HIGH_ADDR) begin
         rd_mux = lock_high_q;
      end
   end

   // Registered read data, held until the next read
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bus_rdata_q <= 8'h00;
      end else if (bus_cmd.rd) begin
         bus_rdata_q <= rd_mux;
      end
   end

   // Abort follows the synchronised reset pin; timing clear follows it only when DC_TIMER_CLR is set
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         abort_q <= 1'b0;
         timing_clear_q <= 1'b0;
      end else begin
         abort_q <= pin_reset;
         timing_clear_q <= pin_reset && dev_cfg_q[DC_TIMER_CLR];
      end
   end

   // Outputs
   assign bus_rdata = bus_rdata_q;
   assign bus_abort = abort_q;
   assign timing_clear = timing_clear_q;
   assign ext_clock_select = ~pin_cfg_q[PC_EXTCLK_SEL];
   assign alert_n_o = 1'b0;
   assign alert_n_oe = alert_q && !pin_cfg_q[PC_ALERT_SEL];

endmodule

// ### pld_host.sv
`timescale 1ns/1ps
module pld_host
   import pld_pkg::*;
(
   // Bus side
   input wire logic core_clk,
   output pld_cmd_t bus_cmd,
   output logic bus_stop,
   input wire logic [7:0] bus_rdata
);
   initial begin
      bus_cmd = '0;
      bus_stop = 1'b0;
   end
   // One request pulse; idle fields go inverted, never stale
   task automatic xfer(input logic r, input logic [7:0] a, d,
                       output logic [7:0] q);
      @(posedge core_clk) bus_cmd <= '{r, !r, a, d};
      @(posedge core_clk) bus_cmd <= '{1'b0, 1'b0, ~a, ~d};
      #1 q = bus_rdata;
   endtask
   // STOP pulse ends a read sequence
   task automatic stop();
      @(posedge core_clk) bus_stop <= 1'b1;
      @(posedge core_clk) bus_stop <= 1'b0;
      #1;
   endtask
endmodule

// ### pld_top_sva.sv
`timescale 1ns/1ps
module pld_top_sva
   import pld_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Watched ports
   input wire logic rst_pin_n,
   input wire pld_cmd_t bus_cmd,
   input wire logic bus_stop,
   input wire logic [7:0] bus_rdata,
   input wire logic bus_abort,
   input wire logic alert_n_o,
   input wire logic alert_n_oe,
   input wire logic timing_clear
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic in_rd_q;
   logic in_rd_d;
   wire port_rd = bus_cmd.rd && bus_cmd.addr >= PORT_REG_FIRST
      && bus_cmd.addr <= PORT_REG_LAST;
   // Read sequence open from a read until STOP or abort
   assign in_rd_d = bus_cmd.rd ? 1'b1
      : (bus_stop || bus_abort) ? 1'b0 : in_rd_q;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         in_rd_q <= 1'b0;
      end else begin
         in_rd_q <= in_rd_d;
      end
   end
   property p_od_low;
      alert_n_o == 1'b0;
   endproperty
   a_od_low: assert property (p_od_low)
      else $error("alert data not low");
   property p_abort;
      $fell(rst_pin_n) |-> ##3 bus_abort;
   endproperty
   a_abort: assert property (p_abort)
      else $error("abort missing");
   property p_hold;
      alert_n_oe && !bus_cmd.rd && !bus_cmd.wr |=> alert_n_oe;
   endproperty
   a_hold: assert property (p_hold)
      else $error("alert dropped without read");
   property p_clr;
      port_rd |=> !alert_n_oe;
   endproperty
   a_clr: assert property (p_clr)
      else $error("alert kept after port read");
   property p_norise;
      $rose(alert_n_oe) |-> !in_rd_q;
   endproperty
   a_norise: assert property (p_norise)
      else $error("alert rose in read sequence");
   property p_lklo;
      bus_cmd.rd && bus_cmd.addr == LOCK_LOW_ADDR
         |=> bus_rdata[2] == 1'b0 && bus_rdata[0] == 1'b0;
   endproperty
   a_lklo: assert property (p_lklo)
      else $error("lock low spare bits set");
   property p_lkhi;
      bus_cmd.rd && bus_cmd.addr == LOCK_HIGH_ADDR
         |=> bus_rdata[7:4] == 4'h0;
   endproperty
   a_lkhi: assert property (p_lkhi)
      else $error("lock high spare bits set");
   property p_tclr;
      timing_clear |-> bus_abort && $past(rst_pin_n, 3) == 1'b0;
   endproperty
   a_tclr: assert property (p_tclr)
      else $error("timing clear without reset pin");
   c_alert: cover property ($rose(alert_n_oe));
   c_abort: cover property ($rose(bus_abort));
   c_tclr: cover property ($rose(timing_clear));
endmodule
bind pld_top pld_top_sva u_pld_top_sva (.core_clk(core_clk),
   .resetn(resetn), .rst_pin_n(rst_pin_n), .bus_cmd(bus_cmd),
   .bus_stop(bus_stop), .bus_rdata(bus_rdata), .bus_abort(bus_abort),
   .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
   .timing_clear(timing_clear));

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
   import pld_pkg::*;
;
   logic core_clk = 1'b0;
   logic timebase_clk = 1'b0;
   logic resetn = 1'b0;
   logic rst_pin_n = 1'b1;
   logic [NPORT-1:0] port_in = '0;
   logic [NPORT-1:0] logic_array_gate = '0;
   pld_cmd_t bus_cmd;
   logic bus_stop, bus_abort, alert_n_o, alert_n_oe;
   logic timing_clear, ext_clock_select;
   logic [7:0] bus_rdata, q;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   always #2.5 core_clk = ~core_clk;
   always #24 timebase_clk = ~timebase_clk;
   pld_top u_pld_top (.core_clk(core_clk), .resetn(resetn),
      .timebase_clk(timebase_clk), .rst_pin_n(rst_pin_n),
      .bus_cmd(bus_cmd), .bus_stop(bus_stop), .bus_rdata(bus_rdata),
      .bus_abort(bus_abort), .port_in(port_in),
      .logic_array_gate(logic_array_gate), .alert_n_o(alert_n_o),
      .alert_n_oe(alert_n_oe), .timing_clear(timing_clear),
      .ext_clock_select(ext_clock_select));
   pld_host u_pld_host (.core_clk(core_clk), .bus_cmd(bus_cmd),
      .bus_stop(bus_stop), .bus_rdata(bus_rdata));
   // Compare and count
   task chk(input logic [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task rdc(input logic [7:0] a, e);
      u_pld_host.xfer(1'b1, a, 8'h00, q);
      chk(q, e);
   endtask
   task wr(input logic [7:0] a, d);
      u_pld_host.xfer(1'b0, a, d, q);
   endtask
   task waitc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task pin_pulse();
      @(posedge core_clk) rst_pin_n <= 1'b0;
      waitc(6);
   endtask
   task tally_and_finish();
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Reset values and unmapped read
   task t_reset();
      rdc(LOCK_LOW_ADDR, 8'h00);
      rdc(LOCK_HIGH_ADDR, 8'h00);
      rdc(8'h05, PORT_RESET);
      rdc(8'h50, 8'h00);
      chk({7'h0, ext_clock_select}, 8'h00);
      u_pld_host.stop();
   endtask
   // Alert raise, reset pin, host clear sequence
   task t_alert();
      wr(PIN_CFG_ADDR, 8'h08);
      chk({7'h0, ext_clock_select}, 8'h01);
      wr(PIN_CFG_ADDR, 8'h0C);
      chk({7'h0, ext_clock_select}, 8'h00);
      wr(8'h02, 8'hA0);
      rdc(8'h02, 8'hA0);
      u_pld_host.stop();
      @(posedge core_clk) port_in[1] <= 1'b1;
      waitc(8);
      chk({7'h0, alert_n_oe}, 8'h01);
      pin_pulse();
      chk({6'h0, bus_abort, alert_n_oe}, 8'h03);
      @(posedge core_clk) rst_pin_n <= 1'b1;
      waitc(6);
      rdc(DEV_CFG_ADDR, 8'h80);
      for (int i = 1; i <= NPORT; i++) begin
         u_pld_host.xfer(1'b1, i[7:0], 8'h00, q);
         if (i == 2) chk(q, 8'hA3);
      end
      u_pld_host.stop();
      chk({7'h0, alert_n_oe}, 8'h00);
      rdc(DEV_CFG_ADDR, 8'h40);
      rdc(8'h02, 8'hA1);
      u_pld_host.stop();
   endtask
   // Flag without alert, change inside a read sequence
   task t_seq();
      @(posedge core_clk) port_in[3] <= 1'b1;
      waitc(8);
      chk({7'h0, alert_n_oe}, 8'h00);
      rdc(8'h04, 8'h83);
      rdc(8'h02, 8'hA1);
      @(posedge core_clk) port_in[1] <= 1'b0;
      waitc(8);
      chk({7'h0, alert_n_oe}, 8'h00);
      rdc(8'h02, 8'hA2);
      u_pld_host.stop();
      waitc(8);
      chk({7'h0, alert_n_oe}, 8'h00);
   endtask
   // Debounced input and output-port monitoring
   task t_debounce();
      wr(8'h06, 8'h84);
      rdc(8'h06, 8'h84);
      @(posedge core_clk) port_in[5] <= 1'b1;
      waitc(20);
      rdc(8'h06, 8'h84);
      waitc(3 * DEBOUNCE_TICKS * 10);
      rdc(8'h06, 8'h87);
      wr(8'h03, 8'h00);
      @(posedge core_clk) port_in[2] <= 1'b1;
      waitc(8);
      rdc(DEV_CFG_ADDR, 8'h40);
      @(posedge core_clk) logic_array_gate[2] <= 1'b1;
      port_in[2] <= 1'b0;
      waitc(8);
      rdc(DEV_CFG_ADDR, 8'h00);
      u_pld_host.stop();
   endtask
   // Write-once locks, then restore reset
   task t_lock();
      wr(LOCK_LOW_ADDR, 8'hFF);
      rdc(LOCK_LOW_ADDR, 8'hFA);
      wr(LOCK_LOW_ADDR, 8'h00);
      rdc(LOCK_LOW_ADDR, 8'hFA);
      wr(LOCK_HIGH_ADDR, 8'hFF);
      rdc(LOCK_HIGH_ADDR, 8'h0F);
      wr(8'h04, 8'h00);
      rdc(8'h04, 8'h81);
      @(posedge core_clk) port_in[3] <= 1'b0;
      waitc(8);
      rdc(8'h04, 8'h82);
      wr(DEV_CFG_ADDR, 8'h03);
      pin_pulse();
      chk({7'h0, timing_clear}, 8'h01);
      @(posedge core_clk) rst_pin_n <= 1'b1;
      waitc(6);
      rdc(LOCK_LOW_ADDR, 8'h00);
      u_pld_host.stop();
   endtask
   // Cycle ceiling against hangs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge core_clk);
      t_reset();
      t_alert();
      t_seq();
      t_debounce();
      t_lock();
      tally_and_finish();
   end
endmodule
